// ### serial_map.vh
// Register offsets, field positions, reset values and timing counts of the serial channel
`ifndef SERIAL_MAP_VH
`define SERIAL_MAP_VH
`define OFS_CONTROL 8'h00
`define OFS_BAUD_RELOAD 8'h04
`define OFS_FRACTIONAL_DIVIDER 8'h08
`define OFS_IRDA_PULSE_CONTROL 8'h0c
`define OFS_TRANSMIT_BUFFER 8'h10
`define OFS_RECEIVE_BUFFER 8'h14
`define OFS_STATUS 8'h18
`define CTL_RUN 15
`define CTL_FDE 11
`define CTL_BRS 13
`define CTL_ODD 12
`define CTL_STP 3
`define CTL_MODE_HI 2
`define CTL_MODE_LO 0
`define PMW_SELECT 8
`define RST_CONTROL 16'h0000
`define RST_BAUD 13'h0000
`define RST_FRACTION 9'h000
`define RST_PULSE 9'h000
`define RST_WORD 9'h000
`define MODE_SYNC 3'h0
`define MODE_IRDA 3'h2
`define MODE_SEVEN_PAR 3'h3
`define MODE_NINE 3'h4
`define MODE_WAKE 3'h5
`define MODE_EIGHT_PAR 3'h7
`define TICKS_PER_BIT_M1 4'hf
`define SAMPLE_PHASE 4'h7
`define IRDA_FIXED_TICKS 4'h3
`endif

// ### fraction_divider.v
// Fractional divider: enable pulses at a rate of n/512 of the input clock
`timescale 1ns/1ps
`default_nettype none
module fraction_divider
(
	input wire pclk,
	input wire presetn,
	input wire [8:0] fraction_numerator,
	output reg div_tick
);
	reg [8:0] accum;
	wire [9:0] sum;

	// Carry out of the phase accumulator marks one output period
	assign sum = {1'b0, accum} + {1'b0, fraction_numerator};

	// Zero numerator bypasses the divider, a tick every cycle
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			accum <= 9'h000;
			div_tick <= 1'b0;
		end
		else if (fraction_numerator == 9'h000)
		begin
			accum <= 9'h000;
			div_tick <= 1'b1;
		end
		else
		begin
			accum <= sum[8:0];
			div_tick <= sum[9];
		end
	end
endmodule // fraction_divider
`default_nettype wire

// ### async_serial_channel.v
// Serial channel: APB registers, baud timer, prescalers, IrDA pulse, buffered transmit and receive
// How it works
// - Reading baud reload returns live 13-bit timer count, not stored reload.
// - Writing baud reload loads both timer count and reload value.
// - Fractional divider scales input clock by n/512, n from 1 to 511.
// - Numerator zero bypasses divider; output equals input clock.
// - Divider prescales baud only in async modes; also feeds autobaud reference.
// - Pulse select clear gives IrDA pulse of three sixteenths bit time.
// - Pulse select set takes IrDA width from programmable count.
// - Programmable width is 8-bit count of input clocks, independent of bit time.
// - Pulse settings act only in IrDA mode, ignored otherwise.
// - Transmit buffer double buffered; accepts write while previous word shifts.
// - Mode 011 puts received parity bit at receive bit seven.
// - Mode 111 puts received parity bit at receive bit eight.
// - Run bit enables baud generator; clear stops it, channel inactive.
// - Prescale enable selects fractional divider in async modes, ignoring divide-by-2/3 choice.
// - Mode 011 frames seven data bits then a parity bit.
// - Mode 010 frames eight data bits with IrDA pulse coding.
`timescale 1ns/1ps
`default_nettype none
`include "serial_map.vh"
module async_serial_channel
(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire rxd,
	output reg txd,
	output reg autobaud_ref
);
	reg [15:0] control;
	reg [12:0] baud_reload_value;
	reg [12:0] baud_count;
	reg [8:0] fraction_numerator;
	reg [8:0] irda_pulse_control;
	reg [8:0] transmit_word;
	reg transmit_buffer_full;
	reg [8:0] receive_word;
	reg rx_full;
	reg [1:0] prescale_count;
	reg baud_tick;
	reg [11:0] tx_shift;
	reg [3:0] tx_bits;
	reg [3:0] tx_phase;
	reg [7:0] pulse_left;
	reg [1:0] rxd_sync;
	reg [8:0] rx_shift;
	reg [3:0] rx_bits;
	reg [3:0] rx_phase;
	reg rx_busy;
	wire div_tick;
	wire [2:0] mode;
	wire run;
	wire irda;
	wire nine;
	wire access;
	wire wr;
	wire rd;
	wire prescale_tick;
	wire tx_load;
	wire [8:0] frame_data;
	wire [3:0] frame_bits;
	wire bit_end;

	// Register match, shared by the read mux and write strobes
	function hit;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			hit = (addr == ofs);
		end
	endfunction

	// Transmit parity over seven or eight data bits
	function parity;
		input [7:0] d;
		input odd;
		begin
			parity = (^d) ^ odd;
		end
	endfunction

	assign mode = control[`CTL_MODE_HI:`CTL_MODE_LO];
	assign run = control[`CTL_RUN];
	assign irda = (mode == `MODE_IRDA);
	assign nine = (mode == `MODE_NINE) || (mode == `MODE_WAKE) || (mode == `MODE_EIGHT_PAR);
	assign access = psel && penable && pready;
	assign wr = access && pwrite;
	assign rd = access && !pwrite;

	fraction_divider u_fraction_divider
	(
		.pclk(pclk),
		.presetn(presetn),
		.fraction_numerator(fraction_numerator),
		.div_tick(div_tick)
	);

	// Divider used only in async modes with enable set, else divide by 2 or 3
	assign prescale_tick = (control[`CTL_FDE] && mode != `MODE_SYNC) ? div_tick :
		(prescale_count == (control[`CTL_BRS] ? 2'h2 : 2'h1));

	// APB: one wait-free access phase; data and ready come from flops
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && paddr > `OFS_STATUS;
			if (psel && !penable)
			begin
				if (hit(paddr, `OFS_CONTROL))
					prdata <= {16'h0000, control};
				else if (hit(paddr, `OFS_BAUD_RELOAD))
					prdata <= {19'h00000, baud_count};
				else if (hit(paddr, `OFS_FRACTIONAL_DIVIDER))
					prdata <= {23'h000000, fraction_numerator};
				else if (hit(paddr, `OFS_IRDA_PULSE_CONTROL))
					prdata <= {23'h000000, irda_pulse_control};
				else if (hit(paddr, `OFS_TRANSMIT_BUFFER))
					prdata <= {23'h000000, transmit_word};
				else if (hit(paddr, `OFS_RECEIVE_BUFFER))
					prdata <= {23'h000000, receive_word};
				else if (hit(paddr, `OFS_STATUS))
					prdata <= {28'h0000000, rx_busy, rx_full, tx_bits != 4'h0, transmit_buffer_full};
				else
					prdata <= 32'h00000000;
			end
		end
	end

	// Software-held configuration
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			control <= `RST_CONTROL;
			baud_reload_value <= `RST_BAUD;
			fraction_numerator <= `RST_FRACTION;
			irda_pulse_control <= `RST_PULSE;
		end
		else if (wr)
		begin
			if (hit(paddr, `OFS_CONTROL))
				control <= pwdata[15:0];
			if (hit(paddr, `OFS_BAUD_RELOAD))
				baud_reload_value <= pwdata[12:0];
			if (hit(paddr, `OFS_FRACTIONAL_DIVIDER))
				fraction_numerator <= pwdata[8:0];
			if (hit(paddr, `OFS_IRDA_PULSE_CONTROL))
				irda_pulse_control <= pwdata[8:0];
		end
	end

	// Prescaler and baud timer; writes during run race the count (software avoids)
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prescale_count <= 2'h0;
			baud_count <= `RST_BAUD;
			baud_tick <= 1'b0;
			autobaud_ref <= 1'b0;
		end
		else
		begin
			autobaud_ref <= div_tick;
			baud_tick <= 1'b0;
			if (!run || prescale_tick)
				prescale_count <= 2'h0;
			else
				prescale_count <= prescale_count + 2'h1;
			if (wr && hit(paddr, `OFS_BAUD_RELOAD))
				baud_count <= pwdata[12:0];
			else if (run && prescale_tick)
			begin
				if (baud_count == 13'h0000)
				begin
					baud_count <= baud_reload_value;
					baud_tick <= 1'b1;
				end
				else
					baud_count <= baud_count - 13'h0001;
			end
		end
	end

	// Frame content: parity replaces the top data bit where selected
	assign frame_data = (mode == `MODE_SEVEN_PAR) ?
		{1'b1, parity({1'b0, transmit_word[6:0]}, control[`CTL_ODD]), transmit_word[6:0]} :
		(mode == `MODE_EIGHT_PAR) ? {parity(transmit_word[7:0], control[`CTL_ODD]),
		transmit_word[7:0]} : nine ? transmit_word : {1'b1, transmit_word[7:0]};
	assign frame_bits = (nine ? 4'ha : 4'h9) + {3'h0, control[`CTL_STP]};
	assign tx_load = run && transmit_buffer_full && tx_bits == 4'h0;
	assign bit_end = baud_tick && tx_phase == `TICKS_PER_BIT_M1;

	// Buffer and shifter; a write landing with the move stays pending
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			transmit_word <= `RST_WORD;
			transmit_buffer_full <= 1'b0;
			tx_shift <= 12'hfff;
			tx_bits <= 4'h0;
			tx_phase <= 4'h0;
		end
		else
		begin
			if (wr && hit(paddr, `OFS_TRANSMIT_BUFFER))
			begin
				transmit_word <= pwdata[8:0];
				transmit_buffer_full <= 1'b1;
			end
			else if (tx_load)
				transmit_buffer_full <= 1'b0;
			if (!run)
			begin
				tx_bits <= 4'h0;
				tx_phase <= 4'h0;
				tx_shift <= 12'hfff;
			end
			else if (tx_load)
			begin
				tx_shift <= {2'h3, frame_data, 1'b0};
				tx_bits <= frame_bits + 4'h1;
				tx_phase <= 4'h0;
			end
			else if (tx_bits != 4'h0 && baud_tick)
			begin
				tx_phase <= tx_phase + 4'h1;
				if (bit_end)
				begin
					tx_shift <= {1'b1, tx_shift[11:1]};
					tx_bits <= tx_bits - 4'h1;
				end
			end
		end
	end

	// IrDA pulse timer in input clocks when programmable width selected
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pulse_left <= 8'h00;
		else if (irda && tx_bits != 4'h0 && !tx_shift[0] && tx_phase == 4'h0 && baud_tick)
			pulse_left <= irda_pulse_control[7:0];
		else if (pulse_left != 8'h00)
			pulse_left <= pulse_left - 8'h01;
	end

	// Line driver: level coding, or a low pulse per zero bit in IrDA mode
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			txd <= 1'b1;
		else if (tx_bits == 4'h0 || !run)
			txd <= 1'b1;
		else if (!irda)
			txd <= tx_shift[0];
		else if (irda_pulse_control[`PMW_SELECT])
			txd <= !(pulse_left != 8'h00 && !tx_shift[0]);
		else
			txd <= !(!tx_shift[0] && tx_phase < `IRDA_FIXED_TICKS);
	end

	// Two-flop input synchroniser
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rxd_sync <= 2'h3;
		else
			rxd_sync <= {rxd_sync[0], rxd};
	end

	// Receiver: mid-bit sampling, start bit rechecked to reject glitches
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_busy <= 1'b0;
			rx_bits <= 4'h0;
			rx_phase <= 4'h0;
			rx_shift <= 9'h000;
		end
		else if (!run)
		begin
			rx_busy <= 1'b0;
			rx_bits <= 4'h0;
			rx_phase <= 4'h0;
		end
		else if (!rx_busy)
		begin
			rx_phase <= 4'h0;
			rx_bits <= 4'h0;
			if (baud_tick && !rxd_sync[1])
				rx_busy <= 1'b1;
		end
		else if (baud_tick)
		begin
			rx_phase <= rx_phase + 4'h1;
			if (rx_phase == `SAMPLE_PHASE)
			begin
				if (rx_bits == 4'h0 && rxd_sync[1])
					rx_busy <= 1'b0;
				else if (rx_bits == (nine ? 4'ha : 4'h9))
					rx_busy <= 1'b0;
				else if (rx_bits != 4'h0)
					rx_shift <= {rxd_sync[1], rx_shift[8:1]};
				rx_bits <= rx_bits + 4'h1;
			end
		end
	end

	// Receive buffer: eight-bit frames sit one place high in the shifter
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			receive_word <= `RST_WORD;
			rx_full <= 1'b0;
		end
		else if (rx_busy && baud_tick && rx_phase == `SAMPLE_PHASE &&
			rx_bits == (nine ? 4'ha : 4'h9))
		begin
			if (nine)
				receive_word <= rx_shift;
			else
				receive_word <= {1'b0, rx_shift[8:1]};
			rx_full <= 1'b1;
		end
		else
		begin
			if (wr && hit(paddr, `OFS_RECEIVE_BUFFER))
				receive_word <= pwdata[8:0];
			if (rd && hit(paddr, `OFS_RECEIVE_BUFFER))
				rx_full <= 1'b0;
		end
	end
endmodule // async_serial_channel
`default_nettype wire

// ### async_serial_channel_asserts.sv
// Port checker of the serial channel
`timescale 1ns/1ps
`default_nettype none
module async_serial_channel_asserts
(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire txd,
	input wire autobaud_ref
);
	reg run;
	reg bok;
	reg fzero;
	reg [12:0] baud;
	wire wr = psel && penable && pready && pwrite;
	wire rd = pready && !pwrite;
	// Shadow of writes; live count equals reload only until run is set
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			run <= 1'b0;
			bok <= 1'b1;
			fzero <= 1'b1;
			baud <= 13'h0000;
		end
		else if (wr)
		begin
			if (paddr == 8'h00)
				run <= pwdata[15];
			if (paddr == 8'h00 && pwdata[15])
				bok <= 1'b0;
			// A reload written while running is overtaken by the count at once
			if (paddr == 8'h04)
				bok <= !run;
			if (paddr == 8'h04)
				baud <= pwdata[12:0];
			if (paddr == 8'h08)
				fzero <= (pwdata[8:0] == 9'h000);
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence
	property p_ready;
		s_setup |=> s_access;
	endproperty
	a_ready: assert property (p_ready) else $error("late pready");
	property p_only;
		pready |-> psel && penable && $past(psel && !penable);
	endproperty
	a_only: assert property (p_only) else $error("stray pready");
	property p_err;
		pready && paddr > 8'h18 |-> pslverr;
	endproperty
	a_err: assert property (p_err) else $error("no pslverr");
	property p_ok;
		pready && paddr <= 8'h18 |-> !pslverr;
	endproperty
	a_ok: assert property (p_ok) else $error("false pslverr");
	property p_zero;
		rd && paddr > 8'h18 |-> prdata == 32'h0;
	endproperty
	a_zero: assert property (p_zero) else $error("unmapped data");
	property p_live;
		rd && paddr == 8'h04 && !run && bok |-> prdata == {19'h0, baud};
	endproperty
	a_live: assert property (p_live) else $error("baud count");
	property p_btop;
		rd && paddr == 8'h04 |-> prdata[31:13] == 19'h0;
	endproperty
	a_btop: assert property (p_btop) else $error("baud upper bits");
	property p_rtop;
		rd && paddr == 8'h14 |-> prdata[31:9] == 23'h0;
	endproperty
	a_rtop: assert property (p_rtop) else $error("receive upper bits");
	property p_bypass;
		fzero [*3] |-> autobaud_ref;
	endproperty
	a_bypass: assert property (p_bypass) else $error("divider not bypassed");
	property p_stopped;
		!run ##1 !run |-> !$fell(txd);
	endproperty
	a_stopped: assert property (p_stopped) else $error("sent while stopped");
endmodule // async_serial_channel_asserts
`default_nettype wire

// ### serial_partner.sv
// Remote serial transceiver model on the line side
`timescale 1ns/1ps
`default_nettype none
module serial_partner
#(parameter int bit_clocks = 32)
(
	input wire logic pclk,
	input wire logic txd,
	output logic rxd
);
	logic [8:0] got [0:3];
	logic [8:0] sh;
	int got_cnt = 0;
	int run_len = 0;
	int last_low = 0;
	initial
		rxd = 1'b1;
	// Width of the last low pulse, for IrDA checks
	always @(posedge pclk)
	begin
		if (!txd)
			run_len <= run_len + 1;
		else
		begin
			if (run_len != 0)
				last_low <= run_len;
			run_len <= 0;
		end
	end
	// Eight-bit receiver, sampling mid-bit, LSB first
	always
	begin
		@(negedge txd);
		repeat (bit_clocks / 2) @(posedge pclk);
		sh = 9'h000;
		for (int i = 0; i < 8; i++)
		begin
			repeat (bit_clocks) @(posedge pclk);
			sh[i] = txd;
		end
		repeat (bit_clocks) @(posedge pclk);
		got[got_cnt % 4] = sh;
		got_cnt++;
	end
	// Start, n bits LSB first, one stop; line rests high
	task send(input logic [8:0] w, input int n);
		rxd <= 1'b0;
		repeat (bit_clocks) @(posedge pclk);
		for (int i = 0; i < n; i++)
		begin
			rxd <= w[i];
			repeat (bit_clocks) @(posedge pclk);
		end
		rxd <= 1'b1;
		repeat (bit_clocks) @(posedge pclk);
	endtask
endmodule // serial_partner
`default_nettype wire

// ### async_serial_channel_bench.sv
// Self-checking bench of the serial channel
`timescale 1ns/1ps
`default_nettype none
module async_serial_channel_bench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] r;
	logic e;
	wire [31:0] prdata;
	wire pready;
	wire pslverr;
	wire txd;
	wire rxd;
	wire autobaud_ref;
	int err_total = 0;
	int checks_done = 0;
	always #25 pclk = ~pclk;
	async_serial_channel i_async_serial_channel (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .autobaud_ref(autobaud_ref));
	// Reload 0 with divide-by-2 gives 32 clocks a bit
	serial_partner #(.bit_clocks(32)) i_serial_partner (.pclk(pclk), .txd(txd), .rxd(rxd));
	task chk(input logic [31:0] g, input logic [31:0] x);
		checks_done++;
		if (g !== x)
		begin
			$display("Error at %0t: got %h exp %h", $time, g, x);
			err_total++;
		end
	endtask
	// One APB transfer; waits for pready without assuming its latency
	task apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			chk(0, 1);
	endtask
	// Poll status until masked bits match
	task poll(input logic [31:0] m, input logic [31:0] v);
		int k;
		k = 0;
		do
		begin
			apb(8'h18, 1'b0, 0);
			k++;
		end
		while ((r & m) !== v && k < 900);
		chk(r & m, v);
	endtask
	task results;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		logic [31:0] v;
		logic [31:0] x;
		logic [8:0] w;
		void'($urandom(50312));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(8'h04, 1'b0, 0);
		chk(r, 0);
		apb(8'h14, 1'b0, 0);
		chk(r, 0);
		apb(8'h1c, 1'b0, 0);
		chk(e, 1);
		repeat (4)
		begin
			v = $urandom;
			apb(8'h04, 1'b1, v);
			apb(8'h04, 1'b0, 0);
			chk(r, v & 32'h1fff);
			apb(8'h08, 1'b1, v);
			apb(8'h08, 1'b0, 0);
			chk(r, v & 32'h1ff);
		end
		apb(8'h08, 1'b1, 0);
		apb(8'h04, 1'b1, 0);
		apb(8'h0c, 1'b1, 32'h105);
		apb(8'h00, 1'b1, 32'h8001);
		v = $urandom & 32'hff;
		x = $urandom & 32'hff;
		apb(8'h10, 1'b1, v);
		apb(8'h10, 1'b1, x);
		poll(32'h3, 0);
		chk(i_serial_partner.got_cnt, 2);
		chk(i_serial_partner.got[0], v);
		chk(i_serial_partner.got[1], x);
		for (int m = 3; m <= 7; m += 4)
		begin
			apb(8'h00, 1'b1, 32'h8000 | m);
			v = $urandom;
			w = (m == 3) ? {1'b0, ^v[6:0], v[6:0]} : {^v[7:0], v[7:0]};
			i_serial_partner.send(w, (m == 3) ? 8 : 9);
			poll(32'h4, 32'h4);
			apb(8'h14, 1'b0, 0);
			chk(r, w);
		end
		// Half-rate fractional prescale with divide-by-3 also selected: still 32 clocks a bit
		apb(8'h08, 1'b1, 32'h100);
		apb(8'h00, 1'b1, 32'ha801);
		v = $urandom & 32'hff;
		apb(8'h10, 1'b1, v);
		poll(32'h3, 0);
		chk(i_serial_partner.got[2], v);
		apb(8'h00, 1'b1, 32'h8002);
		apb(8'h0c, 1'b1, 0);
		apb(8'h10, 1'b1, 0);
		poll(32'h3, 0);
		chk(i_serial_partner.last_low, 6);
		v = 4 + $urandom % 20;
		apb(8'h0c, 1'b1, 32'h100 | v);
		apb(8'h10, 1'b1, 0);
		poll(32'h3, 0);
		chk(i_serial_partner.last_low, v);
		results;
	end
	// Watchdog, well beyond the few thousand cycles of the run
	initial
	begin
		#1000000;
		err_total++;
		results;
	end
endmodule // async_serial_channel_bench
bind async_serial_channel async_serial_channel_asserts i_async_serial_channel_asserts (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.txd(txd), .autobaud_ref(autobaud_ref));
`default_nettype wire
